// *** shared/adcc_pkg.sv ***
// shared constants for the converter control block
package adcc_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned FRC_MAX_KHZ = 500;
  localparam int unsigned FRC_MIN_CYC = (CLK_MHZ * 1000 + FRC_MAX_KHZ - 1) / FRC_MAX_KHZ;
  localparam int unsigned FRC_GAP_W   = $clog2(FRC_MIN_CYC + 1);
  localparam int unsigned ABORT_TAD   = 2;
  localparam int unsigned RES_BITS    = 10;
  // register indices
  localparam logic [2:0] ADDR_CTRL0  = 3'h0;
  localparam logic [2:0] ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] ADDR_RES_HI = 3'h2;
  localparam logic [2:0] ADDR_RES_LO = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  // field positions
  localparam int unsigned C0_JUSTIFY = 7;
  localparam int unsigned C0_REF     = 6;
  localparam int unsigned C0_CHAN_HI = 5;
  localparam int unsigned C0_CHAN_LO = 2;
  localparam int unsigned C0_GO      = 1;
  localparam int unsigned C0_EN      = 0;
  localparam int unsigned C1_CLK_HI  = 6;
  localparam int unsigned C1_CLK_LO  = 4;
  localparam int unsigned ST_DONE    = 0;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  // conversion clock select codes and divider terminal counts
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_FRC   = 2'h3;
  localparam logic [5:0] LAST_DIV2  = 6'h01;
  localparam logic [5:0] LAST_DIV4  = 6'h03;
  localparam logic [5:0] LAST_DIV8  = 6'h07;
  localparam logic [5:0] LAST_DIV16 = 6'h0F;
  localparam logic [5:0] LAST_DIV32 = 6'h1F;
  localparam logic [5:0] LAST_DIV64 = 6'h3F;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_HOLD = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

// *** rtl/adcc_tad_div.sv ***
// conversion clock period enable generator
`timescale 1ns/100ps
module adcc_tad_div (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst,      // async reset
  input  wire logic       run,      // converter powered
  input  wire logic [2:0] clk_sel,  // conversion clock select
  input  wire logic       frc_edge, // qualified dedicated osc edge
  output logic            tad_tick  // one pulse per period
);
  logic [5:0] cnt_r;
  logic [5:0] last;

  // terminal count per divider code
  always_comb
  begin
    unique case (clk_sel)
      adcc_pkg::CLK_DIV2:  last = adcc_pkg::LAST_DIV2;
      adcc_pkg::CLK_DIV4:  last = adcc_pkg::LAST_DIV4;
      adcc_pkg::CLK_DIV8:  last = adcc_pkg::LAST_DIV8;
      adcc_pkg::CLK_DIV16: last = adcc_pkg::LAST_DIV16;
      adcc_pkg::CLK_DIV32: last = adcc_pkg::LAST_DIV32;
      adcc_pkg::CLK_DIV64: last = adcc_pkg::LAST_DIV64;
      default:             last = adcc_pkg::LAST_DIV2; // frc codes, unused
    endcase
  end

  // divide or pass the dedicated oscillator through
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r    <= 6'h00;
      tad_tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r    <= 6'h00;
      tad_tick <= 1'b0;
    end
    else if (clk_sel[1:0] == adcc_pkg::CLK_FRC)
    begin
      cnt_r    <= 6'h00;
      tad_tick <= frc_edge;
    end
    else if (cnt_r >= last)
    begin
      cnt_r    <= 6'h00;
      tad_tick <= 1'b1;
    end
    else
    begin
      cnt_r    <= cnt_r + 6'h01;
      tad_tick <= 1'b0;
    end
  end
endmodule : adcc_tad_div

// *** rtl/adcc_ctrl.sv ***
// converter control, sequencer and result registers
//
// Functional notes
// - justify bit set gives right justified result, clear gives left justified
// - reference bit set selects external reference pin, clear selects supply
// - channel codes 0-11 pick inputs, 12 comparator reference, 13 fixed 0.6 V
// - writing one to the status bit starts a conversion
// - hardware clears the status bit when the conversion ends
// - status bit reads one during a conversion, zero otherwise
// - enable bit powers the converter; clear means off and no current
// - clock field divides by 2,8,32,4,16,64 or picks dedicated oscillator
// - dedicated oscillator edges accepted no faster than 500 kHz
// - left format: bits 9-2 in high byte, bits 1-0 in low byte 7-6
// - right format: bits 9-8 in high byte 1-0, bits 7-0 in low byte
// - unused control 1 bits ignore writes and read zero
// - control registers reset to zero; result bytes keep contents
// - done flag set at every conversion end; software clears it
// - abort keeps old result, then 2 periods before acquisition resumes
// - special event trigger sets the status bit and starts a conversion
`timescale 1ns/100ps
module adcc_ctrl (
  input  wire logic       clk_sys,         // system clock
  input  wire logic       rst,             // async reset
  input  wire logic [2:0] reg_addr,        // register index
  input  wire logic [7:0] reg_wdata,       // write data
  input  wire logic       reg_wr,          // write strobe
  input  wire logic       reg_rd,          // read strobe
  output logic      [7:0] reg_rdata,       // read data, next cycle
  input  wire logic       special_trig,    // compare unit event pulse
  input  wire logic       frc_osc_in,      // dedicated oscillator pin
  input  wire logic       cmp_in,          // comparator: input >= trial
  output logic            afe_enable,      // converter power
  output logic            afe_ref_ext,     // external reference select
  output logic      [3:0] afe_channel,     // mux channel
  output logic            afe_sample,      // sampling switch closed
  output logic      [9:0] dac_code,        // trial code to comparator
  output logic            conv_done_flag   // sticky completion flag
);
  adcc_pkg::adcc_state_t state_r;
  logic       justify_r;
  logic       ref_r;
  logic [3:0] chan_r;
  logic       go_r;
  logic       en_r;
  logic [2:0] clksel_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] hold_cnt_r;
  logic       frc_s1_r;
  logic       frc_s2_r;
  logic       frc_s3_r;
  logic       frc_edge_r;
  logic [adcc_pkg::FRC_GAP_W-1:0] frc_gap_r;
  logic       cmp_s1_r;
  logic       tad_tick;
  logic       wr_c0;
  logic       en_nxt;
  logic       start;
  logic       abort;
  logic       done;
  logic [9:0] mask;
  logic [9:0] sar_dec;
  logic [7:0] hi_nxt;
  logic [7:0] lo_nxt;

  // write decode and sequencer events
  assign wr_c0  = reg_wr && (reg_addr == adcc_pkg::ADDR_CTRL0);
  assign en_nxt = wr_c0 ? reg_wdata[adcc_pkg::C0_EN] : en_r;
  assign start  = (state_r == adcc_pkg::ST_IDLE) && en_nxt
                  && ((wr_c0 && reg_wdata[adcc_pkg::C0_GO]) || special_trig);
  assign abort  = (state_r == adcc_pkg::ST_CONV)
                  && ((wr_c0 && !reg_wdata[adcc_pkg::C0_GO]) || !en_nxt);
  assign done   = (state_r == adcc_pkg::ST_CONV) && tad_tick && !abort
                  && (bit_cnt_r == 4'(adcc_pkg::RES_BITS));

  // successive approximation decision on the current trial bit
  // comparator only answers our own registered trial code, so one retiming
  // stage is enough; two stages would miss the two-cycle fastest period
  assign mask    = 10'h200 >> (bit_cnt_r - 4'h1);
  assign sar_dec = cmp_s1_r ? dac_code : (dac_code & ~mask);

  // result placement by format
  assign hi_nxt = justify_r ? {6'h00, sar_dec[9:8]} : sar_dec[9:2];
  assign lo_nxt = justify_r ? sar_dec[7:0] : {sar_dec[1:0], 6'h00};

  // conversion clock period enable
  adcc_tad_div adcc_tad_div_i (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (en_r),
    .clk_sel  (clksel_r),
    .frc_edge (frc_edge_r),
    .tad_tick (tad_tick)
  );

  // oscillator pin synchroniser and comparator retiming
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      frc_s1_r <= 1'b0;
      frc_s2_r <= 1'b0;
      frc_s3_r <= 1'b0;
      cmp_s1_r <= 1'b0;
    end
    else
    begin
      frc_s1_r <= frc_osc_in;
      frc_s2_r <= frc_s1_r;
      frc_s3_r <= frc_s2_r;
      cmp_s1_r <= cmp_in; // read by the decision one cycle later
    end
  end

  // dedicated oscillator edge qualifier, rate limited
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      frc_gap_r  <= '0;
      frc_edge_r <= 1'b0;
    end
    else if (frc_s2_r && !frc_s3_r && (frc_gap_r >= adcc_pkg::FRC_GAP_W'(adcc_pkg::FRC_MIN_CYC - 1)))
    begin
      frc_gap_r  <= '0;
      frc_edge_r <= 1'b1;
    end
    else
    begin
      if (frc_gap_r < adcc_pkg::FRC_GAP_W'(adcc_pkg::FRC_MIN_CYC - 1))
        frc_gap_r <= frc_gap_r + 1'b1;
      frc_edge_r <= 1'b0;
    end
  end

  // control register 0 fields
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      justify_r <= adcc_pkg::CTRL0_RST[adcc_pkg::C0_JUSTIFY];
      ref_r     <= adcc_pkg::CTRL0_RST[adcc_pkg::C0_REF];
      chan_r    <= adcc_pkg::CTRL0_RST[adcc_pkg::C0_CHAN_HI:adcc_pkg::C0_CHAN_LO];
      en_r      <= adcc_pkg::CTRL0_RST[adcc_pkg::C0_EN];
    end
    else if (wr_c0)
    begin
      justify_r <= reg_wdata[adcc_pkg::C0_JUSTIFY];
      ref_r     <= reg_wdata[adcc_pkg::C0_REF];
      chan_r    <= reg_wdata[adcc_pkg::C0_CHAN_HI:adcc_pkg::C0_CHAN_LO];
      en_r      <= reg_wdata[adcc_pkg::C0_EN];
    end
  end

  // control register 1, only the clock field is stored
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clksel_r <= adcc_pkg::CTRL1_RST[adcc_pkg::C1_CLK_HI:adcc_pkg::C1_CLK_LO];
    else if (reg_wr && (reg_addr == adcc_pkg::ADDR_CTRL1))
      clksel_r <= reg_wdata[adcc_pkg::C1_CLK_HI:adcc_pkg::C1_CLK_LO];
  end

  // status bit: set on start, cleared by hardware at end or abort
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      go_r <= adcc_pkg::CTRL0_RST[adcc_pkg::C0_GO];
    else if (start)
      go_r <= 1'b1;
    else if (done || abort)
      go_r <= 1'b0;
  end

  // sequencer state
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= adcc_pkg::ST_IDLE;
    else
    begin
      unique case (state_r)
        adcc_pkg::ST_IDLE:
          if (start)
            state_r <= adcc_pkg::ST_CONV;
        adcc_pkg::ST_CONV:
          if (abort)
            state_r <= en_nxt ? adcc_pkg::ST_HOLD : adcc_pkg::ST_IDLE;
          else if (done)
            state_r <= adcc_pkg::ST_IDLE;
        adcc_pkg::ST_HOLD:
          if (!en_r || (tad_tick && hold_cnt_r == 2'(adcc_pkg::ABORT_TAD - 1)))
            state_r <= adcc_pkg::ST_IDLE;
        default:
          state_r <= adcc_pkg::ST_IDLE;
      endcase
    end
  end

  // holdoff period counter after abort
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hold_cnt_r <= 2'h0;
    else if (state_r != adcc_pkg::ST_HOLD)
      hold_cnt_r <= 2'h0;
    else if (tad_tick)
      hold_cnt_r <= hold_cnt_r + 2'h1;
  end

  // bit counter and trial code
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_r <= 4'h0;
      dac_code  <= 10'h000;
    end
    else if (start)
    begin
      bit_cnt_r <= 4'h0;
      dac_code  <= 10'h200;
    end
    else if ((state_r == adcc_pkg::ST_CONV) && tad_tick && !done)
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r != 4'h0)
        dac_code <= sar_dec | (mask >> 1);
    end
  end

  // result bytes: no reset, both written in one cycle at completion
  always_ff @(posedge clk_sys)
  begin
    if (done)
    begin
      res_hi_r <= hi_nxt;
      res_lo_r <= lo_nxt;
    end
    else if (reg_wr && (reg_addr == adcc_pkg::ADDR_RES_HI))
      res_hi_r <= reg_wdata;
    else if (reg_wr && (reg_addr == adcc_pkg::ADDR_RES_LO))
      res_lo_r <= reg_wdata;
  end

  // done flag: set wins over write-one-to-clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      conv_done_flag <= 1'b0;
    else if (done)
      conv_done_flag <= 1'b1;
    else if (reg_wr && (reg_addr == adcc_pkg::ADDR_STATUS) && reg_wdata[adcc_pkg::ST_DONE])
      conv_done_flag <= 1'b0;
  end

  // front end controls
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      afe_enable  <= 1'b0;
      afe_ref_ext <= 1'b0;
      afe_channel <= 4'h0;
      afe_sample  <= 1'b0;
    end
    else
    begin
      afe_enable  <= en_r;
      afe_ref_ext <= ref_r;
      afe_channel <= chan_r;
      afe_sample  <= en_r && (state_r == adcc_pkg::ST_IDLE) && !start;
    end
  end

  // registered read data, zero outside the read answer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      unique case (reg_addr)
        adcc_pkg::ADDR_CTRL0:  reg_rdata <= {justify_r, ref_r, chan_r, go_r, en_r};
        adcc_pkg::ADDR_CTRL1:  reg_rdata <= {1'b0, clksel_r, 4'h0};
        adcc_pkg::ADDR_RES_HI: reg_rdata <= res_hi_r;
        adcc_pkg::ADDR_RES_LO: reg_rdata <= res_lo_r;
        adcc_pkg::ADDR_STATUS: reg_rdata <= {7'h00, conv_done_flag};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence abort_seq;
    abort && en_nxt;
  endsequence

  sequence finish_seq;
    done ##1 (!go_r && conv_done_flag);
  endsequence

  go_busy_a: assert property (go_r == (state_r == adcc_pkg::ST_CONV))
    else $error("status bit disagrees with busy state");
  start_go_a: assert property (start |=> go_r && !afe_sample)
    else $error("start did not set status bit");
  off_nostart_a: assert property (go_r |-> en_r)
    else $error("conversion running while disabled");
  done_clear_a: assert property (done |-> finish_seq)
    else $error("status bit not cleared at end");
  flag_set_a: assert property (done |=> conv_done_flag ##1 (conv_done_flag || $past(reg_wr)))
    else $error("done flag not set");
  abort_hold_a: assert property (abort_seq |=> !afe_sample [*2] ##0 $stable(res_hi_r))
    else $error("abort changed result or resumed early");
  right_fmt_a: assert property (done && justify_r |=> res_hi_r[7:2] == 6'h00
                                 && {res_hi_r[1:0], res_lo_r} == $past(sar_dec))
    else $error("right justified result wrong");
  left_fmt_a: assert property (done && !justify_r |=> res_lo_r[5:0] == 6'h00
                                && {res_hi_r, res_lo_r[7:6]} == $past(sar_dec))
    else $error("left justified result wrong");
  c1_zero_a: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_CTRL1
                               |=> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
    else $error("unused control 1 bits not zero");
  frc_rate_a: assert property (frc_edge_r |-> $past(frc_gap_r) >= (adcc_pkg::FRC_MIN_CYC - 1))
    else $error("dedicated clock edges too close");
  trig_go_a: assert property (special_trig && !reg_wr && en_r && state_r == adcc_pkg::ST_IDLE |=> go_r)
    else $error("trigger did not start conversion");
  dac_start_a: assert property (start |=> dac_code == 10'h200 && bit_cnt_r == 4'h0)
    else $error("conversion did not start at mid scale");
endmodule : adcc_ctrl

// *** sim/adcc_afe_model.sv ***
// analog front end model: channel mux, hold capacitor and comparator
`timescale 1ns/100ps
module adcc_afe_model #(
  parameter int ACQ_CYC = 16 // sampling cycles before the hold settles
) (
  input  wire logic       clk_sys,     // system clock
  input  wire logic       afe_enable,  // converter power
  input  wire logic       afe_ref_ext, // reference select
  input  wire logic [3:0] afe_channel, // mux channel
  input  wire logic       afe_sample,  // sampling switch
  input  wire logic [9:0] dac_code,    // trial code
  output logic            cmp_in       // comparator decision
);
  logic [9:0] held    = 10'h000;
  logic [3:0] last_ch = 4'h0;
  int         acq     = 0;
  logic       tgl     = 1'b0;

  // input level per channel and reference, as a code
  function automatic logic [9:0] level(input logic [3:0] ch, input logic ext);
    level = ext ? ~{ch, 6'h2A} : {ch, 6'h2A};
  endfunction : level

  // hold follows the channel only after a full acquisition
  always @(posedge clk_sys)
  begin
    tgl <= ~tgl;
    if (!afe_sample || afe_channel != last_ch)
      acq <= 0;
    else if (acq < ACQ_CYC)
      acq <= acq + 1;
    else
      held <= level(afe_channel, afe_ref_ext);
    last_ch <= afe_channel;
  end

  // unpowered comparator toggles so no stale level looks valid
  assign cmp_in = afe_enable ? (held >= dac_code) : tgl;
endmodule : adcc_afe_model

// *** sim/adcc_ctrl_test.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcc_ctrl_test;
  logic       clk_sys;
  logic       rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       special_trig;
  logic       frc_osc_in;
  logic       cmp_in;
  logic       afe_enable;
  logic       afe_ref_ext;
  logic [3:0] afe_channel;
  logic       afe_sample;
  logic [9:0] dac_code;
  logic       conv_done_flag;
  logic [7:0] d;
  int         miscompares;
  int         cmp_count;

  adcc_ctrl adcc_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_trig(special_trig), .frc_osc_in(frc_osc_in),
    .cmp_in(cmp_in), .afe_enable(afe_enable), .afe_ref_ext(afe_ref_ext), .afe_channel(afe_channel),
    .afe_sample(afe_sample), .dac_code(dac_code), .conv_done_flag(conv_done_flag));

  adcc_afe_model adcc_afe_model_i (
    .clk_sys(clk_sys), .afe_enable(afe_enable), .afe_ref_ext(afe_ref_ext), .afe_channel(afe_channel),
    .afe_sample(afe_sample), .dac_code(dac_code), .cmp_in(cmp_in));

  // system clock and a dedicated oscillator at 400 kHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    frc_osc_in = 1'b0;
    forever #1250 frc_osc_in = ~frc_osc_in;
  end

  task automatic final_report();
    $display("miscompares %0d compares %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // register bus cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // bounded wait for the sampling switch to close again
  task automatic wait_idle(output int n);
    n = 0;
    while (afe_sample !== 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 20000)
    begin
      miscompares++;
      final_report();
    end
  endtask : wait_idle

  // reset values, unused bits and an unmapped index
  task automatic reg_checks();
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d, 8'h00);
    rd(adcc_pkg::ADDR_CTRL1, d);
    chk(d, 8'h00);
    wr(adcc_pkg::ADDR_CTRL1, 8'hFF);
    rd(adcc_pkg::ADDR_CTRL1, d);
    chk(d, 8'h70);
    wr(3'h5, 8'hFF);
    rd(3'h5, d);
    chk(d, 8'h00);
  endtask : reg_checks

  // start request with the converter off must not start
  task automatic no_go();
    wr(adcc_pkg::ADDR_CTRL0, 8'h02);
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d[1], 1'b0);
    chk(afe_enable, 1'b0);
    chk(afe_sample, 1'b0);
  endtask : no_go

  // full conversion with a given clock, format, reference and channel
  task automatic run_conv(input logic [2:0] sel, input logic just, input logic ext, input logic [3:0] ch);
    int         n;
    int         dv;
    logic [9:0] r;
    r  = adcc_afe_model_i.level(ch, ext);
    dv = (sel[1:0] == 2'b11) ? 500 : (2 << (2 * sel[1:0] + sel[2]));
    wr(adcc_pkg::ADDR_STATUS, 8'h01);
    chk(conv_done_flag, 1'b0);
    wr(adcc_pkg::ADDR_CTRL1, {1'b0, sel, 4'h0});
    wr(adcc_pkg::ADDR_CTRL0, {just, ext, ch, 2'b01});
    repeat (40) @(posedge clk_sys); // acquisition after channel change
    chk(afe_channel, ch);
    chk(afe_ref_ext, ext);
    chk(afe_enable, 1'b1);
    wr(adcc_pkg::ADDR_CTRL0, {just, ext, ch, 2'b11});
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d[1], 1'b1);
    wait_idle(n);
    chk((n >= 10 * dv) && (n <= 12 * dv + 8), 1'b1);
    chk(conv_done_flag, 1'b1);
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d[1], 1'b0);
    rd(adcc_pkg::ADDR_RES_HI, d);
    if (just)
      chk(d[1:0], r[9:8]);
    else
      chk(d, r[9:2]);
    rd(adcc_pkg::ADDR_RES_LO, d);
    if (just)
      chk(d, r[7:0]);
    else
      chk(d[7:6], r[1:0]);
  endtask : run_conv

  // abort mid conversion keeps result and holds off two periods
  task automatic abort_conv();
    int         n;
    logic [7:0] hi;
    wr(adcc_pkg::ADDR_STATUS, 8'h01);
    rd(adcc_pkg::ADDR_RES_HI, hi);
    wr(adcc_pkg::ADDR_CTRL1, 8'h60);
    wr(adcc_pkg::ADDR_CTRL0, 8'h35);
    repeat (40) @(posedge clk_sys);
    wr(adcc_pkg::ADDR_CTRL0, 8'h37);
    repeat (200) @(posedge clk_sys);
    wr(adcc_pkg::ADDR_CTRL0, 8'h35);
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d[1], 1'b0);
    chk(afe_sample, 1'b0);
    wait_idle(n);
    chk((n >= 60) && (n <= 200), 1'b1);
    rd(adcc_pkg::ADDR_RES_HI, d);
    chk(d, hi);
    chk(conv_done_flag, 1'b0);
  endtask : abort_conv

  // compare unit event starts a conversion alone
  task automatic trig_conv();
    int n;
    wr(adcc_pkg::ADDR_CTRL1, 8'h20);
    repeat (40) @(posedge clk_sys);
    special_trig <= 1'b1;
    @(posedge clk_sys);
    special_trig <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(afe_sample, 1'b0);
    chk(dac_code, 10'h200);
    wait_idle(n);
    chk(conv_done_flag, 1'b1);
    rd(adcc_pkg::ADDR_RES_HI, d);
    chk(d, adcc_afe_model_i.level(4'hD, 1'b0) >> 2);
  endtask : trig_conv

  // reset mid conversion clears control, keeps the low result byte
  task automatic mid_reset();
    logic [7:0] lo;
    rd(adcc_pkg::ADDR_RES_LO, lo);
    wr(adcc_pkg::ADDR_CTRL0, 8'h37);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(afe_enable, 1'b0);
    rd(adcc_pkg::ADDR_CTRL0, d);
    chk(d, 8'h00);
    rd(adcc_pkg::ADDR_CTRL1, d);
    chk(d, 8'h00);
    rd(adcc_pkg::ADDR_RES_LO, d);
    chk(d, lo);
  endtask : mid_reset

  // main sequence; channel codes stay within 0 to 13
  initial
  begin
    rst          = 1'b1;
    reg_addr     = 3'h0;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    special_trig = 1'b0;
    miscompares  = 0;
    cmp_count    = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    reg_checks();
    no_go();
    for (int i = 0; i < 8; i++)
      run_conv(3'(i), i[0], i[1], 4'(i + 6));
    abort_conv();
    trig_conv();
    mid_reset();
    final_report();
  end
endmodule : adcc_ctrl_test
